// >>> src/scb_regs.vh
`ifndef SCB_REGS_VH
`define SCB_REGS_VH

// ----------------------------------------------------------------------
// register addresses: word addresses, plus byte and halfword addresses of the fault subregisters
// ----------------------------------------------------------------------
`define SCB_AUX_CONTROL       32'hE000E008
`define SCB_CPU_IDENT         32'hE000ED00
`define SCB_INT_CTRL_STATE    32'hE000ED04
`define SCB_VECTOR_OFFSET     32'hE000ED08
`define SCB_APP_INT_RESET     32'hE000ED0C
`define SCB_SYSTEM_CONTROL    32'hE000ED10
`define SCB_CONFIG_CONTROL    32'hE000ED14
`define SCB_HANDLER_PRIO_ONE  32'hE000ED18
`define SCB_HANDLER_PRIO_TWO  32'hE000ED1C
`define SCB_HANDLER_PRIO_TRI  32'hE000ED20
`define SCB_HANDLER_CTRL      32'hE000ED24
`define SCB_CFG_FAULT_STATUS  32'hE000ED28
`define SCB_MEM_FAULT_BYTE    32'hE000ED28
`define SCB_BUS_FAULT_BYTE    32'hE000ED29
`define SCB_USAGE_FAULT_HALF  32'hE000ED2A
`define SCB_HARD_FAULT_STATUS 32'hE000ED2C
`define SCB_MEM_FAULT_ADDR    32'hE000ED34
`define SCB_BUS_FAULT_ADDR    32'hE000ED38
`define SCB_EVT_STATUS        32'hE000ED40
`define SCB_EVT_CLEAR         32'hE000ED44
`define SCB_EVT_ENABLE        32'hE000ED48

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SCB_AUX_CONTROL_RST   32'h00000000
`define SCB_ZERO_RST          32'h00000000
`define SCB_CONFIG_RST        32'h00000200
`define SCB_CPU_IDENT_DEFAULT 32'h5A5A0001 // arbitrary value

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define SCB_FOLD_OFF_BIT      2
`define SCB_WBUF_OFF_BIT      1
`define SCB_MCYC_OFF_BIT      0
`define SCB_PENDSV_SET_BIT    28
`define SCB_PENDSV_CLR_BIT    27
`define SCB_PENDST_SET_BIT    26
`define SCB_PENDST_CLR_BIT    25
`define SCB_ISR_PENDING_BIT   22
`define SCB_RET_TO_BASE_BIT   11
`define SCB_SYSRESETREQ_BIT   2
`define SCB_VEC_OFFSET_MASK   32'h3FFFFF80
`define SCB_APP_KEY           16'h05FA
`define SCB_APP_KEY_STAT      16'hFA05
`define SCB_EVT_WIDTH         4

`endif

// >>> src/scb_system_control.v
// Function
// - fold off: no first conditional-block instruction while the opener still runs.
// - default-map write buffer off: stores drain before next instruction; faults precise.
// - that buffer-off bit touches only the core's own write buffers.
// - multicycle irq off: load/store multiple finishes before the interrupt is taken.
// - with folding on, the first conditional instruction may start early.
// - fault status word has byte, byte, halfword subregisters at consecutive bytes.
// - handler priority registers are also an array of single priority bytes.
// - unmask instruction clears the global irq mask; mask instruction sets it.
`include "scb_regs.vh"

module scb_system_control #(
   parameter [31:0] CPU_IDENT_VALUE = `SCB_CPU_IDENT_DEFAULT
) (
   input  wire        clk,
   input  wire        reset,
   // wishbone classic slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [31:0] wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   output reg         wb_err_o,
   input  wire        priv_access,
   // core status and events
   input  wire [8:0]  vect_active,
   input  wire [9:0]  vect_pending,
   input  wire        isr_pending,
   input  wire        ret_to_base,
   input  wire        systick_fire,
   input  wire        pendsv_taken,
   input  wire        pendst_taken,
   input  wire [31:0] cfg_fault_set,
   input  wire [31:0] hard_fault_set,
   input  wire        mem_fault_load,
   input  wire        bus_fault_load,
   input  wire [31:0] fault_address,
   // core pipeline hooks
   input  wire        cond_open_busy,
   input  wire        fold_candidate,
   input  wire        default_map_store,
   input  wire        store_pending,
   input  wire        irq_request,
   input  wire        multi_xfer_busy,
   input  wire        irq_unmask_instruction,
   input  wire        irq_mask_instruction,
   // control outputs
   output wire        fold_off,
   output wire        default_map_wbuf_off,
   output wire        multicycle_irq_off,
   output wire        fold_issue,
   output wire        core_wbuf_bypass,
   output wire        issue_stall,
   output wire        bus_fault_precise,
   output wire        irq_take,
   output reg         irq_masked,
   output reg         pendsv_pending,
   output reg         pendst_pending,
   output reg  [2:0]  priority_group,
   output reg         sys_reset_req,
   output wire [31:0] vector_table_base,
   output wire [31:0] system_control,
   output wire [31:0] configuration_control,
   output wire [31:0] handler_control_state,
   output wire        scb_irq
);

   // -------------------------------------------------------------------
   // bus decode
   // -------------------------------------------------------------------
   wire [31:0] adr_w;
   wire        req;
   wire        idle;
   wire        do_wr;
   wire [31:0] bmask;
   wire [31:0] wmask;
   reg         hit;

   assign adr_w = {wb_adr_i[31:2], 2'b00};
   assign req   = wb_cyc_i & wb_stb_i;
   assign idle  = ~wb_ack_o & ~wb_err_o;
   // a write lands only on the edge where ack is seen high by the master
   assign do_wr = req & wb_we_i & wb_ack_o;
   assign bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                   {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign wmask = wb_dat_i & bmask;

   always @* begin
      case (adr_w)
         `SCB_AUX_CONTROL,
         `SCB_CPU_IDENT,
         `SCB_INT_CTRL_STATE,
         `SCB_VECTOR_OFFSET,
         `SCB_APP_INT_RESET,
         `SCB_SYSTEM_CONTROL,
         `SCB_CONFIG_CONTROL,
         `SCB_HANDLER_PRIO_ONE,
         `SCB_HANDLER_PRIO_TWO,
         `SCB_HANDLER_PRIO_TRI,
         `SCB_HANDLER_CTRL,
         `SCB_CFG_FAULT_STATUS,
         `SCB_HARD_FAULT_STATUS,
         `SCB_MEM_FAULT_ADDR,
         `SCB_BUS_FAULT_ADDR,
         `SCB_EVT_STATUS,
         `SCB_EVT_CLEAR,
         `SCB_EVT_ENABLE: hit = 1'b1;
         default:         hit = 1'b0;
      endcase
   end

   wire refuse;
   assign refuse = ~priv_access | ~hit;

   wire we_aux   = do_wr & (adr_w == `SCB_AUX_CONTROL);
   wire we_ictl  = do_wr & (adr_w == `SCB_INT_CTRL_STATE);
   wire we_vec   = do_wr & (adr_w == `SCB_VECTOR_OFFSET);
   wire we_app   = do_wr & (adr_w == `SCB_APP_INT_RESET);
   wire we_sctl  = do_wr & (adr_w == `SCB_SYSTEM_CONTROL);
   wire we_cctl  = do_wr & (adr_w == `SCB_CONFIG_CONTROL);
   wire we_shcsr = do_wr & (adr_w == `SCB_HANDLER_CTRL);
   wire we_cfs   = do_wr & (adr_w == `SCB_CFG_FAULT_STATUS);
   wire we_hfs   = do_wr & (adr_w == `SCB_HARD_FAULT_STATUS);
   wire we_madr  = do_wr & (adr_w == `SCB_MEM_FAULT_ADDR);
   wire we_badr  = do_wr & (adr_w == `SCB_BUS_FAULT_ADDR);
   wire we_eclr  = do_wr & (adr_w == `SCB_EVT_CLEAR);
   wire we_een   = do_wr & (adr_w == `SCB_EVT_ENABLE);

   // -------------------------------------------------------------------
   // handshake: ack or err one cycle after the request, for one cycle
   // -------------------------------------------------------------------
   always @(posedge clk) begin
      if (reset) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
      end else begin
         wb_ack_o <= req & idle & ~refuse;
         wb_err_o <= req & idle & refuse;
      end
   end

   // -------------------------------------------------------------------
   // plain control registers
   // -------------------------------------------------------------------
   reg [31:0] aux_control;
   reg [31:0] vector_table_offset;
   reg [31:0] system_ctrl;
   reg [31:0] config_ctrl;
   reg [31:0] handler_ctrl;

   always @(posedge clk) begin
      if (reset) begin
         aux_control         <= `SCB_AUX_CONTROL_RST;
         vector_table_offset <= `SCB_ZERO_RST;
         system_ctrl         <= `SCB_ZERO_RST;
         config_ctrl         <= `SCB_CONFIG_RST;
         handler_ctrl        <= `SCB_ZERO_RST;
      end else begin
         if (we_aux) begin
            aux_control[2:0] <= (aux_control[2:0] & ~bmask[2:0]) | wmask[2:0];
         end
         if (we_vec) begin
            vector_table_offset <= ((vector_table_offset & ~bmask) | wmask)
                                   & `SCB_VEC_OFFSET_MASK;
         end
         if (we_sctl) begin
            system_ctrl <= (system_ctrl & ~bmask) | wmask;
         end
         if (we_cctl) begin
            config_ctrl <= (config_ctrl & ~bmask) | wmask;
         end
         if (we_shcsr) begin
            handler_ctrl <= (handler_ctrl & ~bmask) | wmask;
         end
      end
   end

   assign fold_off              = aux_control[`SCB_FOLD_OFF_BIT];
   assign default_map_wbuf_off  = aux_control[`SCB_WBUF_OFF_BIT];
   assign multicycle_irq_off    = aux_control[`SCB_MCYC_OFF_BIT];
   assign vector_table_base     = vector_table_offset;
   assign system_control        = system_ctrl;
   assign configuration_control = config_ctrl;
   assign handler_control_state = handler_ctrl;

   // -------------------------------------------------------------------
   // handler priority byte array, one byte lane per entry
   // -------------------------------------------------------------------
   reg  [7:0] handler_priority_bytes [0:11];
   wire [1:0] prio_word;

   assign prio_word = (adr_w == `SCB_HANDLER_PRIO_ONE) ? 2'd0 :
                      (adr_w == `SCB_HANDLER_PRIO_TWO) ? 2'd1 :
                      (adr_w == `SCB_HANDLER_PRIO_TRI) ? 2'd2 : 2'd3;

   genvar gi;
   generate
      for (gi = 0; gi < 12; gi = gi + 1) begin : g_prio
         always @(posedge clk) begin
            if (reset) begin
               handler_priority_bytes[gi] <= 8'h00;
            end else if (do_wr && prio_word == gi / 4 && wb_sel_i[gi % 4]) begin
               handler_priority_bytes[gi] <= wb_dat_i[8 * (gi % 4) +: 8];
            end
         end
      end
   endgenerate

   // -------------------------------------------------------------------
   // interrupt control and state, priority grouping, reset request
   // -------------------------------------------------------------------
   wire sv_set = we_ictl & wmask[`SCB_PENDSV_SET_BIT];
   wire sv_clr = we_ictl & wmask[`SCB_PENDSV_CLR_BIT];
   wire st_set = (we_ictl & wmask[`SCB_PENDST_SET_BIT]) | systick_fire;
   wire st_clr = (we_ictl & wmask[`SCB_PENDST_CLR_BIT]) | pendst_taken;
   wire key_ok = we_app & (wb_sel_i[3:2] == 2'b11)
                 & (wb_dat_i[31:16] == `SCB_APP_KEY);

   always @(posedge clk) begin
      if (reset) begin
         pendsv_pending <= 1'b0;
         pendst_pending <= 1'b0;
         priority_group <= 3'h0;
         sys_reset_req  <= 1'b0;
      end else begin
         // set wins over a clear in the same cycle
         pendsv_pending <= (pendsv_pending & ~(sv_clr | pendsv_taken)) | sv_set;
         pendst_pending <= (pendst_pending & ~st_clr) | st_set;
         if (key_ok && wb_sel_i[1]) begin
            priority_group <= wb_dat_i[10:8];
         end
         sys_reset_req <= key_ok & wb_sel_i[0] & wb_dat_i[`SCB_SYSRESETREQ_BIT];
      end
   end

   // -------------------------------------------------------------------
   // fault status, write one to clear; hardware set wins
   // -------------------------------------------------------------------
   reg [31:0] configurable_fault_status;
   reg [31:0] hard_fault_status;

   always @(posedge clk) begin
      if (reset) begin
         configurable_fault_status <= `SCB_ZERO_RST;
         hard_fault_status         <= `SCB_ZERO_RST;
      end else begin
         // byte lanes give the memory, bus and usage subregisters
         configurable_fault_status <= (configurable_fault_status
                                       & ~(we_cfs ? wmask : 32'h00000000))
                                      | cfg_fault_set;
         hard_fault_status <= (hard_fault_status
                               & ~(we_hfs ? wmask : 32'h00000000)) | hard_fault_set;
      end
   end

   // fault addresses carry no reset: software must not trust them before a fault
   reg [31:0] memory_manage_fault_address;
   reg [31:0] bus_fault_address;

   always @(posedge clk) begin
      if (mem_fault_load) begin
         memory_manage_fault_address <= fault_address;
      end else if (we_madr) begin
         memory_manage_fault_address <= (memory_manage_fault_address & ~bmask) | wmask;
      end
      if (bus_fault_load) begin
         bus_fault_address <= fault_address;
      end else if (we_badr) begin
         bus_fault_address <= (bus_fault_address & ~bmask) | wmask;
      end
   end

   // -------------------------------------------------------------------
   // block events and interrupt output
   // -------------------------------------------------------------------
   reg  [`SCB_EVT_WIDTH-1:0] evt_status;
   reg  [`SCB_EVT_WIDTH-1:0] evt_enable;
   wire [`SCB_EVT_WIDTH-1:0] evt_in;
   wire [`SCB_EVT_WIDTH-1:0] evt_clr;

   assign evt_in  = {sys_reset_req, |hard_fault_set, |cfg_fault_set, req & wb_err_o};
   assign evt_clr = we_eclr ? wmask[`SCB_EVT_WIDTH-1:0] : {`SCB_EVT_WIDTH{1'b0}};

   always @(posedge clk) begin
      if (reset) begin
         evt_status <= {`SCB_EVT_WIDTH{1'b0}};
         evt_enable <= {`SCB_EVT_WIDTH{1'b0}};
      end else begin
         evt_status <= (evt_status & ~evt_clr) | evt_in;
         if (we_een) begin
            evt_enable <= wmask[`SCB_EVT_WIDTH-1:0];
         end
      end
   end

   assign scb_irq = |(evt_status & evt_enable);

   // -------------------------------------------------------------------
   // core hooks
   // -------------------------------------------------------------------
   always @(posedge clk) begin
      if (reset) begin
         irq_masked <= 1'b0;
      end else if (irq_mask_instruction) begin
         irq_masked <= 1'b1;
      end else if (irq_unmask_instruction) begin
         irq_masked <= 1'b0;
      end
   end

   // folding trades loop jitter for speed; fold_off restores strict order
   assign fold_issue = fold_candidate & (~cond_open_busy | ~fold_off);

   // only the core buffer is bypassed; system buffers see no signal from here
   assign core_wbuf_bypass  = default_map_wbuf_off & default_map_store;
   assign issue_stall       = default_map_wbuf_off & store_pending;
   assign bus_fault_precise = default_map_wbuf_off;

   // longer latency is the price of never restarting a multiple transfer
   assign irq_take = irq_request & ~irq_masked
                     & ~(multicycle_irq_off & multi_xfer_busy);

   // -------------------------------------------------------------------
   // read data, sampled with the request and held through ack
   // -------------------------------------------------------------------
   reg [31:0] rd;
   wire [3:0] pb;

   assign pb = {prio_word, 2'b00};

   always @* begin
      case (adr_w)
         `SCB_AUX_CONTROL:       rd = aux_control;
         `SCB_CPU_IDENT:         rd = CPU_IDENT_VALUE;
         `SCB_INT_CTRL_STATE:    rd = {3'h0, pendsv_pending, 1'b0, pendst_pending,
                                       3'h0, isr_pending, vect_pending,
                                       ret_to_base, 2'h0, vect_active};
         `SCB_VECTOR_OFFSET:     rd = vector_table_offset;
         `SCB_APP_INT_RESET:     rd = {`SCB_APP_KEY_STAT, 5'h00, priority_group,
                                       8'h00};
         `SCB_SYSTEM_CONTROL:    rd = system_ctrl;
         `SCB_CONFIG_CONTROL:    rd = config_ctrl;
         `SCB_HANDLER_PRIO_ONE,
         `SCB_HANDLER_PRIO_TWO,
         `SCB_HANDLER_PRIO_TRI:  rd = {handler_priority_bytes[pb + 4'd3],
                                       handler_priority_bytes[pb + 4'd2],
                                       handler_priority_bytes[pb + 4'd1],
                                       handler_priority_bytes[pb]};
         `SCB_HANDLER_CTRL:      rd = handler_ctrl;
         `SCB_CFG_FAULT_STATUS:  rd = configurable_fault_status;
         `SCB_HARD_FAULT_STATUS: rd = hard_fault_status;
         `SCB_MEM_FAULT_ADDR:    rd = memory_manage_fault_address;
         `SCB_BUS_FAULT_ADDR:    rd = bus_fault_address;
         `SCB_EVT_STATUS:        rd = {28'h0000000, evt_status};
         `SCB_EVT_ENABLE:        rd = {28'h0000000, evt_enable};
         default:                rd = 32'h00000000;
      endcase
   end

   always @(posedge clk) begin
      if (reset) begin
         wb_dat_o <= 32'h00000000;
      end else if (req && idle) begin
         wb_dat_o <= (refuse || wb_we_i) ? 32'h00000000 : rd;
      end
   end

endmodule

// >>> tb/scb_system_control_sva.sv
// ----------------------------------------------------------------------
// port-level checks of the system control register bank
// ----------------------------------------------------------------------
module scb_system_control_sva (
   input logic clk,
   input logic reset,
   input logic wb_cyc_i,
   input logic wb_stb_i,
   input logic priv_access,
   input logic wb_ack_o,
   input logic wb_err_o,
   input logic cond_open_busy,
   input logic fold_candidate,
   input logic default_map_store,
   input logic store_pending,
   input logic irq_request,
   input logic multi_xfer_busy,
   input logic irq_unmask_instruction,
   input logic irq_mask_instruction,
   input logic fold_off,
   input logic default_map_wbuf_off,
   input logic multicycle_irq_off,
   input logic fold_issue,
   input logic core_wbuf_bypass,
   input logic issue_stall,
   input logic bus_fault_precise,
   input logic irq_take,
   input logic irq_masked
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // a request counts only while no answer is out, as the slave sees it
   wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;

   fold_block_a: assert property (fold_off && cond_open_busy |-> !fold_issue)
      else $error("block instruction issued beside a busy opener");
   fold_early_a: assert property (!fold_off && fold_candidate |-> fold_issue)
      else $error("folding enabled but candidate held back");
   store_drain_a: assert property (default_map_wbuf_off && store_pending |-> issue_stall)
      else $error("issue not stalled behind pending store");
   precise_fault_a: assert property (bus_fault_precise == default_map_wbuf_off)
      else $error("precise fault flag differs from buffer-off bit");
   core_only_a: assert property (
      core_wbuf_bypass == (default_map_wbuf_off && default_map_store))
      else $error("write buffer bypass outside default-map stores");
   multi_whole_a: assert property (multicycle_irq_off && multi_xfer_busy |-> !irq_take)
      else $error("interrupt taken inside a multiple transfer");
   mask_set_a: assert property (irq_mask_instruction |=> irq_masked)
      else $error("mask instruction left interrupts unmasked");
   unmask_clr_a: assert property (
      irq_unmask_instruction && !irq_mask_instruction |=> !irq_masked)
      else $error("unmask instruction left interrupts masked");
   refuse_user_a: assert property (req && !priv_access |=> wb_err_o && !wb_ack_o)
      else $error("unprivileged access not refused");

   cover property (req && !priv_access);
   cover property (fold_off && cond_open_busy && fold_candidate);
   cover property (irq_mask_instruction ##[1:4] irq_unmask_instruction);
endmodule

bind scb_system_control scb_system_control_sva i_scb_system_control_sva (
   .clk, .reset, .wb_cyc_i, .wb_stb_i, .priv_access, .wb_ack_o, .wb_err_o, .cond_open_busy,
   .fold_candidate, .default_map_store, .store_pending, .irq_request, .multi_xfer_busy,
   .irq_unmask_instruction, .irq_mask_instruction, .fold_off, .default_map_wbuf_off,
   .multicycle_irq_off, .fold_issue, .core_wbuf_bypass, .issue_stall, .bus_fault_precise,
   .irq_take, .irq_masked);

// >>> tb/tb_top.sv
`include "scb_regs.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, reset, cyc, stb, we, priv, isr, rtb, cob, fcand, dms, sp, ireq, lsb;
   logic        unm, msk, mfl, ack, err, fo, wo, mo, fi, byp, stall, prec, take, masked, irq;
   logic        svp, stp, srr;
   logic [31:0] adr, dat, cfs, hfs, fadr, rdat, vtb, sco, cco, hco;
   logic [3:0]  sel;
   logic [8:0]  va;
   logic [9:0]  vp;
   logic [2:0]  pg;
   logic [32:0] qd[$], qm[$];
   int          errors, checked;

   scb_system_control i_scb_system_control (
      .clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
      .priv_access(priv), .vect_active(va), .vect_pending(vp), .isr_pending(isr),
      .ret_to_base(rtb), .systick_fire(1'b0), .pendsv_taken(1'b0), .pendst_taken(1'b0),
      .cfg_fault_set(cfs), .hard_fault_set(hfs), .mem_fault_load(mfl), .bus_fault_load(mfl),
      .fault_address(fadr), .cond_open_busy(cob), .fold_candidate(fcand),
      .default_map_store(dms), .store_pending(sp), .irq_request(ireq), .multi_xfer_busy(lsb),
      .irq_unmask_instruction(unm), .irq_mask_instruction(msk), .fold_off(fo),
      .default_map_wbuf_off(wo), .multicycle_irq_off(mo), .fold_issue(fi),
      .core_wbuf_bypass(byp), .issue_stall(stall), .bus_fault_precise(prec), .irq_take(take),
      .irq_masked(masked), .pendsv_pending(svp), .pendst_pending(stp), .priority_group(pg),
      .sys_reset_req(srr), .vector_table_base(vtb), .system_control(sco),
      .configuration_control(cco), .handler_control_state(hco), .scb_irq(irq));

   // ----------------------------------------------------------------------
   // bus driver, answer monitor and compares
   // ----------------------------------------------------------------------
   task automatic chk(input logic [32:0] got, e, m);
      checked++;
      if ((got & m) !== e) begin
         errors++;
         $display("MISMATCH %0t bus got %h exp %h", $time, got & m, e);
      end
   endtask
   task automatic chk_flag(input logic [31:0] got, e);
      checked++;
      if (got !== e) begin
         errors++;
         $display("MISMATCH %0t flags got %h exp %h", $time, got, e);
      end
   endtask
   task automatic bus(input logic w, input logic [31:0] a, d, input logic [3:0] s,
                      input logic [32:0] e, m);
      qd.push_back(e);
      qm.push_back(m);
      @(posedge clk);
      {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, s, d};
      // no own limit: a slave that never answers is caught by the watchdog
      do @(posedge clk);
      while (!(ack | err));
      {cyc, stb, we} <= 3'b000;
   endtask
   task automatic rd(input logic [31:0] a, input logic [3:0] s, input logic [31:0] e, m);
      bus(1'b0, a, 32'h0, s, {1'b0, e & m}, {1'b1, m});
   endtask
   task automatic wr(input logic [31:0] a, input logic [3:0] s, input logic [31:0] d);
      bus(1'b1, a, d, s, 33'h0, {33{1'b1}});
   endtask
   task automatic final_report;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   always @(posedge clk) begin
      if (ack | err) begin
         if (qd.size() == 0) begin
            errors++;
            $display("MISMATCH %0t unexpected answer", $time);
         end else
            chk({err, rdat}, qd.pop_front(), qm.pop_front());
      end
   end

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      $display("MISMATCH %0t watchdog expired", $time);
      final_report;
   end

   initial begin
      logic [31:0] d, e, g;
      logic [31:0] ra[13];
      logic [31:0] rv[13];
      logic [7:0]  pb[12];
      logic [1:0]  mu[3];
      logic        v;
      ra = '{`SCB_AUX_CONTROL, `SCB_CPU_IDENT, `SCB_INT_CTRL_STATE, `SCB_VECTOR_OFFSET,
             `SCB_APP_INT_RESET, `SCB_SYSTEM_CONTROL, `SCB_CONFIG_CONTROL,
             `SCB_HANDLER_PRIO_ONE, `SCB_HANDLER_PRIO_TWO, `SCB_HANDLER_PRIO_TRI,
             `SCB_HANDLER_CTRL, `SCB_CFG_FAULT_STATUS, `SCB_HARD_FAULT_STATUS};
      rv = '{32'h0, `SCB_CPU_IDENT_DEFAULT, 32'h0, 32'h0, 32'hFA050000, 32'h0, 32'h00000200,
             32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
      mu = '{2'b10, 2'b01, 2'b11};
      {cyc, stb, we, isr, rtb, cob, fcand, dms, sp, ireq, lsb, unm, msk, mfl} = '0;
      {adr, dat, cfs, hfs, fadr, sel, va, vp} = '0;
      {reset, priv} = 2'b11;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      d = $urandom(32'hD5C05E9C);
      for (int i = 0; i < 13; i++) rd(ra[i], 4'hF, rv[i], 32'hFFFFFFFF);
      priv <= 1'b0;
      bus(1'b1, `SCB_AUX_CONTROL, 32'h7, 4'hF, 33'h100000000, {33{1'b1}});
      priv <= 1'b1;
      bus(1'b0, 32'hE000ED3C, 32'h0, 4'hF, 33'h100000000, {33{1'b1}});
      rd(`SCB_AUX_CONTROL, 4'hF, 32'h0, 32'hFFFFFFFF);
      $display("test reset and refusal done");
      rd(`SCB_EVT_STATUS, 4'hF, 32'h1, 32'hFFFFFFFF);
      chk_flag(irq, 1'b0);
      for (int i = 0; i < 2; i++) begin
         wr(i ? `SCB_EVT_CLEAR : `SCB_EVT_ENABLE, 4'hF, 32'h1);
         @(negedge clk);
         chk_flag(irq, i ? 1'b0 : 1'b1);
      end
      rd(`SCB_EVT_STATUS, 4'hF, 32'h0, 32'hFFFFFFFF);
      $display("test interrupt done");
      d = $urandom;
      wr(`SCB_AUX_CONTROL, 4'hF, d);
      rd(`SCB_AUX_CONTROL, 4'hF, d & 32'h7, 32'hFFFFFFFF);
      for (int a = 0; a < 2; a++) begin
         v = a[0];
         wr(`SCB_AUX_CONTROL, 4'hF, {29'h0, {3{v}}});
         for (int k = 0; k < 64; k++) begin
            @(posedge clk);
            {cob, fcand, dms, sp, ireq, lsb} <= k[5:0];
            @(negedge clk);
            chk_flag({fo, wo, mo, fi, byp, stall, prec, take}, {v, v, v, fcand & (~cob | ~v),
                     v & dms, v & sp, v, ireq & ~(v & lsb)});
         end
      end
      $display("test pipeline hooks done");
      {ireq, lsb} <= 2'b10;
      for (int k = 0; k < 3; k++) begin
         @(posedge clk);
         {msk, unm} <= mu[k];
         @(posedge clk);
         {msk, unm} <= 2'b00;
         @(negedge clk);
         chk_flag({masked, take}, {mu[k][1], ~mu[k][1]});
      end
      $display("test irq mask done");
      d = $urandom;
      e = $urandom;
      g = $urandom;
      @(posedge clk);
      {cfs, hfs, fadr, mfl} <= {d, e, g, 1'b1};
      {isr, rtb, vp, va} <= e[20:0];
      @(posedge clk);
      {cfs, hfs, mfl} <= '0;
      rd(`SCB_INT_CTRL_STATE, 4'hF, {9'h0, e[20], e[18:9], e[19], 2'b0, e[8:0]}, 32'hFFFFFFFF);
      rd(`SCB_HARD_FAULT_STATUS, 4'hF, e, 32'hFFFFFFFF);
      rd(`SCB_MEM_FAULT_ADDR, 4'hF, g, 32'hFFFFFFFF);
      rd(`SCB_BUS_FAULT_ADDR, 4'hF, g, 32'hFFFFFFFF);
      rd(`SCB_MEM_FAULT_BYTE, 4'b0001, d, 32'h000000FF);
      rd(`SCB_BUS_FAULT_BYTE, 4'b0010, d, 32'h0000FF00);
      rd(`SCB_USAGE_FAULT_HALF, 4'b1100, d, 32'hFFFF0000);
      wr(`SCB_BUS_FAULT_BYTE, 4'b0010, 32'hFFFFFFFF);
      rd(`SCB_CFG_FAULT_STATUS, 4'hF, d & 32'hFFFF00FF, 32'hFFFFFFFF);
      $display("test fault status done");
      for (int n = 0; n < 12; n++) begin
         pb[n] = $urandom;
         d = $urandom;
         d[8 * (n % 4) +: 8] = pb[n];
         wr(`SCB_HANDLER_PRIO_ONE + n, 4'b0001 << n % 4, d);
      end
      for (int w = 0; w < 3; w++)
         rd(`SCB_HANDLER_PRIO_ONE + 4 * w, 4'hF, {pb[4 * w + 3], pb[4 * w + 2], pb[4 * w + 1],
            pb[4 * w]}, 32'hFFFFFFFF);
      $display("test priority bytes done");
      wr(`SCB_APP_INT_RESET, 4'hF, 32'h12340500);
      rd(`SCB_APP_INT_RESET, 4'hF, 32'hFA050000, 32'hFFFFFFFF);
      wr(`SCB_APP_INT_RESET, 4'hF, 32'h05FA0304);
      @(negedge clk);
      chk_flag(srr, 1'b1);
      rd(`SCB_APP_INT_RESET, 4'hF, 32'hFA050300, 32'hFFFFFFFF);
      chk_flag(pg, 3'h3);
      rd(`SCB_EVT_STATUS, 4'hF, 32'h8, 32'h00000008);
      d = $urandom;
      e = $urandom;
      g = $urandom;
      wr(`SCB_VECTOR_OFFSET, 4'hF, d);
      wr(`SCB_SYSTEM_CONTROL, 4'hF, e);
      wr(`SCB_CONFIG_CONTROL, 4'hF, g);
      wr(`SCB_HANDLER_CTRL, 4'hF, d ^ e);
      wr(`SCB_INT_CTRL_STATE, 4'hF, 32'h14000000);
      @(negedge clk);
      chk_flag({svp, stp}, 2'b11);
      chk_flag(vtb, d & `SCB_VEC_OFFSET_MASK);
      chk_flag(sco, e);
      chk_flag(cco, g);
      chk_flag(hco, d ^ e);
      wr(`SCB_INT_CTRL_STATE, 4'hF, 32'h0A000000);
      @(negedge clk);
      chk_flag({svp, stp}, 2'b00);
      $display("test reset control done");
      final_report;
   end
endmodule
